//--- rtl/sces_regs.sv
`timescale 1ns/10ps
`include "sces_defs.svh"
module sces_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] esm_state_i,
  input wire logic comm_shutdown_i,
  input wire logic gen_out_cmd_i,
  input wire logic gen_out_idle_i,
  input wire logic servo_on_i,
  input wire logic [15:0] torque_offset_obj_i,
  input wire logic [15:0] latch_delay_comp_primary_i,
  input wire logic [15:0] latch_delay_comp_falling_i,
  input wire logic target_reached_i,
  input wire logic torque_limiting_i,
  input wire logic speed_limiting_i,
  input wire logic cyclic_torque_mode_i,
  input wire logic [7:0] rotary_address_switch_i,
  input wire logic [15:0] slave_info_interface_i,
  output logic general_output_one_o,
  output logic [15:0] torque_offset_o,
  output logic [15:0] latch_rise_comp_o,
  output logic [15:0] latch_fall_comp_o,
  output logic follows_command_o,
  output logic [15:0] station_alias_o
);
  sces_pkg::sces_state_t st;
  sces_pkg::sces_state_t next_st;
  logic req;
  logic limited;

  //////////////////////////////////////////////////////////////////////////
  // Single-cycle classic slave: ack one cycle after the request, then drop.
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  // Speed limiting only counts in cyclic torque mode.
  assign limited = torque_limiting_i || (speed_limiting_i && cyclic_torque_mode_i);

  always_comb begin
    next_st = st;
    next_st.ack = req;
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        `SCES_ADDR_EXT_SETUP: begin
          // Bits stored as written; the host keeps the fixed reserved values.
          if (wb_sel_i[0]) next_st.ext_setup[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_st.ext_setup[15:8] = wb_dat_i[15:8];
        end
        `SCES_ADDR_ALIAS_HIGH: begin
          if (wb_sel_i[0]) next_st.alias_high = wb_dat_i[7:0];
        end
        `SCES_ADDR_ALIAS_SRC: begin
          if (wb_sel_i[0]) next_st.alias_src = wb_dat_i[1:0];
        end
        default: begin
        end
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `SCES_ADDR_EXT_SETUP: next_st.rdata = {16'h0000, st.ext_setup};
        `SCES_ADDR_ALIAS_HIGH: next_st.rdata = {24'h000000, st.alias_high};
        `SCES_ADDR_ALIAS_SRC: next_st.rdata = {30'h00000000, st.alias_src};
        default: next_st.rdata = 32'h00000000;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Establishment is remembered so a drop to Init during shutdown still counts.
    if (esm_state_i > 3'(sces_pkg::SCES_ESM_PREOP)) next_st.established = 1'b1;
    else if (esm_state_i == 3'(sces_pkg::SCES_ESM_INIT) && !comm_shutdown_i) begin
      next_st.established = 1'b0;
    end
    if (comm_shutdown_i && st.established) begin
      if (st.ext_setup[`SCES_BIT_SHUT_INIT]) next_st.gen_out = gen_out_idle_i;
    end else begin
      next_st.gen_out = gen_out_cmd_i;
    end

    next_st.latch_rise_comp = latch_delay_comp_primary_i;
    next_st.latch_fall_comp = st.ext_setup[`SCES_BIT_LATCH_SPLIT] ?
        latch_delay_comp_falling_i : latch_delay_comp_primary_i;

    if (servo_on_i || st.ext_setup[`SCES_BIT_TQ_KEEP]) begin
      next_st.torque_offset = torque_offset_obj_i;
    end else begin
      next_st.torque_offset = 16'h0000;
    end

    next_st.following = target_reached_i &&
        (st.ext_setup[`SCES_BIT_FOLLOW_EXCL] || !limited);

    if (st.alias_src == 2'h1) next_st.station_alias = slave_info_interface_i;
    else next_st.station_alias = {st.alias_high, rotary_address_switch_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ext_setup <= `SCES_EXT_RESET;
      st.alias_high <= `SCES_ALIAS_HIGH_RESET;
      st.alias_src <= `SCES_ALIAS_SRC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign general_output_one_o = st.gen_out;
  assign torque_offset_o = st.torque_offset;
  assign latch_rise_comp_o = st.latch_rise_comp;
  assign latch_fall_comp_o = st.latch_fall_comp;
  assign follows_command_o = st.following;
  assign station_alias_o = st.station_alias;
endmodule

//--- rtl/sces_defs.svh
// Functional notes
// - Bit 0 low holds general output on shutdown; high returns it to command-zero level.
// - Shutdown output behaviour applies only once link state passed Pre-Operational.
// - Bit 5 low uses primary latch delay both edges; high uses falling setting for falls.
// - Servo off: bit 7 low clears internal torque offset; high keeps tracking object.
// - Bit 11 low includes torque and cyclic-torque speed limiting in following status.
// - Upper alias byte comes from alias high register unless alias source is 1, range 0 to 255.
// - Alias source 0 uses rotary switch plus high register; 1 uses slave info value.
`ifndef SCES_DEFS_SVH
`define SCES_DEFS_SVH
`define SCES_ADDR_EXT_SETUP 4'h0
`define SCES_ADDR_RSVD_SPECIAL 4'h4
`define SCES_ADDR_ALIAS_HIGH 4'h8
`define SCES_ADDR_ALIAS_SRC 4'hC
`define SCES_ADDR_STATUS 4'h0
`define SCES_BIT_SHUT_INIT 0
`define SCES_BIT_LATCH_SPLIT 5
`define SCES_BIT_TQ_KEEP 7
`define SCES_BIT_FOLLOW_EXCL 11
`define SCES_EXT_RESET 16'h3010
`define SCES_ALIAS_HIGH_RESET 8'h00
`define SCES_ALIAS_SRC_RESET 2'h0
`endif

//--- rtl/sces_pkg.sv
package sces_pkg;
  typedef enum logic [2:0] {
    SCES_ESM_INIT,
    SCES_ESM_PREOP,
    SCES_ESM_BOOT,
    SCES_ESM_SAFEOP,
    SCES_ESM_OP
  } sces_esm_t;

  typedef struct packed {
    logic [15:0] ext_setup;
    logic [7:0] alias_high;
    logic [1:0] alias_src;
    logic established;
    logic ack;
    logic [31:0] rdata;
    logic gen_out;
    logic [15:0] torque_offset;
    logic [15:0] latch_rise_comp;
    logic [15:0] latch_fall_comp;
    logic following;
    logic [15:0] station_alias;
  } sces_state_t;
endpackage

//--- verification/sces_regs_sva.sv
`timescale 1ns/10ps
module sces_regs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] latch_delay_comp_primary_i,
  input wire logic [15:0] latch_rise_comp_o,
  input wire logic target_reached_i,
  input wire logic follows_command_o,
  input wire logic comm_shutdown_i,
  input wire logic gen_out_cmd_i,
  input wire logic general_output_one_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack unasked");
  rise_comp_a: assert property (
    1'b1 |=> latch_rise_comp_o == $past(latch_delay_comp_primary_i)) else $error("rise comp");
  follow_gate_a: assert property (
    !target_reached_i |=> !follows_command_o) else $error("follow without target");
  out_follow_a: assert property (
    !comm_shutdown_i |=> general_output_one_o == $past(gen_out_cmd_i)) else $error("out cmd");
endmodule

//--- verification/sces_host.sv
`timescale 1ns/10ps
module sces_host (
  input wire logic [3:0] sel_i,
  output logic [15:0] word_o
);
  assign word_o = {4'h3, sel_i[3], 3'h0, sel_i[2], 1'h0, sel_i[1], 1'h1, 3'h0, sel_i[0]};
endmodule

//--- verification/servo_comm_extended_setup_regs_test.sv
`timescale 1ns/10ps
module servo_comm_extended_setup_regs_test;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic comm_shutdown_i = 1'h0, gen_out_cmd_i = 1'h1, gen_out_idle_i = 1'h0;
  logic servo_on_i = 1'h1, target_reached_i = 1'h0, torque_limiting_i = 1'h0;
  logic speed_limiting_i = 1'h0, cyclic_torque_mode_i = 1'h0;
  logic wb_ack_o, general_output_one_o, follows_command_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [2:0] esm_state_i = 3'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] torque_offset_obj_i = 16'h0042, latch_delay_comp_primary_i = 16'h1234;
  logic [15:0] latch_delay_comp_falling_i = 16'h5678, slave_info_interface_i = 16'hBEEF;
  logic [15:0] word, torque_offset_o, latch_rise_comp_o, latch_fall_comp_o, station_alias_o;
  logic [7:0] rotary_address_switch_i = 8'hA5;
  int error_cnt, n_tests, cycles;
  logic [35:0] rows [4] = '{{4'h0, 16'h38B1, 16'h38B1}, {4'h4, 16'hFFFF, 16'h0000},
    {4'h8, 16'h00FF, 16'h00FF}, {4'hC, 16'h0001, 16'h0001}};
  wire logic [65:0] outs = {station_alias_o, latch_rise_comp_o, latch_fall_comp_o,
    torque_offset_o, follows_command_o, general_output_one_o};
  sces_regs dut (.*);
  sces_host host (.sel_i(4'hF), .word_o(word));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cycles > 2000) end_of_test(1);
  // Ack and read data are sampled at the rising edge, before that edge's update lands.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [65:0] g, input logic [65:0] e);
    n_tests++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic end_of_test(input int bad);
    $display("errors=%0d tests=%0d", error_cnt + bad, n_tests);
    if (error_cnt + bad == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    bus(1'h0, 4'h0, 32'h0);
    chk(rd, 32'h3010);
    chk(word, 16'h38B1);
    {comm_shutdown_i, torque_limiting_i, servo_on_i, target_reached_i} <= 4'hD;
    foreach (rows[i]) begin
      bus(1'h1, rows[i][35:32], {16'h0000, rows[i][31:16]});
      bus(1'h0, rows[i][35:32], 32'h0);
      chk(rd, rows[i][15:0]);
    end
    chk(outs, {16'hBEEF, 16'h1234, 16'h5678, 16'h0042, 2'h3});
    esm_state_i <= 3'h4;
    bus(1'h1, 4'hC, 32'h0);
    chk(outs, {16'hFFA5, 16'h1234, 16'h5678, 16'h0042, 2'h2});
    bus(1'h1, 4'h0, 32'h3010);
    chk(outs, {16'hFFA5, 16'h1234, 16'h1234, 16'h0000, 2'h0});
    rst_i <= 1'h1;
    servo_on_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk(outs, 66'h0);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk(outs, {16'h00A5, 16'h1234, 16'h1234, 16'h0042, 2'h1});
    bus(1'h0, 4'h0, 32'h0);
    chk(rd, 32'h3010);
    end_of_test(0);
  end
endmodule
bind sces_regs sces_regs_sva sva (.*);
